// ### arf_pkg.sv
// Purpose: shared constants for the ready flag and serial port block
// Assumes: 24-bit converter words, 8-bit command byte
// Notes: apb offsets are byte addresses
package arf_pkg;
	// ==========================================
	// widths
	localparam int WORD_W = 24;
	localparam int COMM_W = 8;
	localparam int SEL_W = 3;
	localparam int MODE_W = 2;
	localparam int IRQ_W = 4;
	// ==========================================
	// command byte fields
	localparam int COMM_RD_BIT = 6;
	localparam int SEL_LSB = 0;
	localparam logic [SEL_W-1:0] SEL_COMM_STAT = 3'h0;
	localparam logic [SEL_W-1:0] SEL_DATA = 3'h1;
	localparam logic [SEL_W-1:0] SEL_MODE = 3'h2;
	localparam logic [SEL_W-1:0] SEL_FILT = 3'h3;
	localparam logic [SEL_W-1:0] SEL_DAC = 3'h4;
	localparam logic [SEL_W-1:0] SEL_OFFS = 3'h5;
	localparam logic [SEL_W-1:0] SEL_GAIN = 3'h6;
	// ==========================================
	// internal register fields
	localparam int MODE_LSB = 0;
	localparam logic [MODE_W-1:0] MODE_IDLE = 2'h0;
	localparam logic [MODE_W-1:0] MODE_CONV = 2'h1;
	localparam logic [MODE_W-1:0] MODE_CAL = 2'h2;
	localparam int CHOP_BIT = 4;
	localparam int STAT_RDY = 7;
	localparam int STAT_CAL = 6;
	localparam int STAT_CHOP = 5;
	// ==========================================
	// reset values
	localparam logic [COMM_W-1:0] COMM_RST = 8'h00;
	localparam logic [WORD_W-1:0] MODE_RST = 24'h00_0000;
	localparam logic [WORD_W-1:0] FILT_RST = 24'h00_0010;
	localparam logic [WORD_W-1:0] DAC_RST = 24'h00_0000;
	localparam logic [WORD_W-1:0] OFFS_RST = 24'h80_0000;
	localparam logic [WORD_W-1:0] GAIN_RST = 24'h80_0000;
	// ==========================================
	// apb map and interrupt bits
	localparam logic [11:0] OFF_IRQ_STAT = 12'h000;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h004;
	localparam logic [11:0] OFF_STATE = 12'h008;
	localparam logic [11:0] OFF_DATA = 12'h00C;
	localparam int IRQ_NEW = 0;
	localparam int IRQ_CAL = 1;
	localparam int IRQ_MISS = 2;
	localparam int IRQ_BADWR = 3;
	// ==========================================
	// port sequencer states
	typedef enum logic [1:0] {
		ST_CMD = 2'b00,
		ST_RD = 2'b01,
		ST_WR = 2'b10
	} arf_state_e;
endpackage

// ### arf_sp_if.sv
// Purpose: link between port sequencer and bit shifter
// Assumes: one clock domain
// Notes: load is a one-cycle pulse
`timescale 1ns/1ps
interface arf_sp_if #(parameter int W = 24);
	logic load;
	logic [$clog2(W+1)-1:0] len;
	logic [W-1:0] tx_word;
	logic done;
	logic [W-1:0] rx_word;
	logic frame;
	modport shifter (input load, len, tx_word, output done, rx_word, frame);
	modport ctrl (output load, len, tx_word, input done, rx_word, frame);
endinterface

// ### arf_shifter.sv
// Purpose: samples the serial pins and shifts words in and out
// Assumes: host changes din on sclk fall, samples dout on sclk rise
// Notes: pins pass two flops before use
`timescale 1ns/1ps
module arf_shifter import arf_pkg::*; #(
	parameter int W = WORD_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic din,
	input wire logic cs_n,
	output logic dout,
	arf_sp_if.shifter sp
);
	localparam int LW = $clog2(W+1);
	// ==========================================
	// pin synchronisers
	wire [2:0] pin_raw;
	wire [2:0] pin_s;
	logic sclk_d;
	logic [LW-1:0] cnt;
	logic [W-1:0] rx_sh;
	logic [W-1:0] tx_sh;
	logic rise;
	logic last;
	assign pin_raw = {cs_n, din, sclk};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			logic q1;
			logic q2;
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					q1 <= 1'b1;
					q2 <= 1'b1;
				end else if (ce) begin
					q1 <= pin_raw[i];
					q2 <= q1;
				end
			end
			assign pin_s[i] = q2;
		end
	endgenerate
	assign sp.frame = !pin_s[2];
	assign rise = pin_s[0] && !sclk_d && sp.frame;
	assign last = (cnt == LW'(sp.len - 1'b1));
	assign dout = tx_sh[W-1];
	// ==========================================
	// edge finder and bit count
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sclk_d <= 1'b1;
		end else if (ce) begin
			sclk_d <= pin_s[0];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt <= '0;
		end else if (ce) begin
			if (!sp.frame) begin
				cnt <= '0;
			end else if (rise) begin
				cnt <= last ? '0 : LW'(cnt + 1'b1);
			end
		end
	end
	// ==========================================
	// shift registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_sh <= '0;
			sp.rx_word <= '0;
			sp.done <= 1'b0;
		end else if (ce) begin
			sp.done <= rise && last;
			if (rise) begin
				rx_sh <= {rx_sh[W-2:0], pin_s[1]};
			end
			if (rise && last) begin
				sp.rx_word <= {rx_sh[W-2:0], pin_s[1]};
			end
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_sh <= '0;
		end else if (ce) begin
			if (sp.load) begin
				tx_sh <= sp.tx_word << (W - int'(sp.len));
			end else if (rise) begin
				tx_sh <= {tx_sh[W-2:0], 1'b0};
			end
		end
	end
	// ==========================================
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_IDLE_FRAME_CLEARS: assert property (
		ce && !sp.frame |=> cnt == '0 && !sp.done)
		else $error("bit count not cleared outside frame");
endmodule // arf_shifter

// ### arf_top.sv
// Purpose: ready flag, serial register routing and apb status for a bridge converter
// Assumes: converter core pulses upd_start, upd_done, cal_done on ref_clk
// Notes: apb answers with no wait state while ce is high
`timescale 1ns/1ps
// What this block does
// - in conversion mode, rdy_n goes low when a fresh word sits in data
// - rdy_n goes high once the host has read a full data word
// - unread data: rdy_n high before next update, held during it, low after
// - calibration: rdy_n high at start, low when calibration completes
// - output shifter loads the register chosen by the select field
// - input shifter writes only writable registers; status and data never written
// - chopping and non-chopping operation both supported, host selects
// - with cs_n tied low the port runs on sclk, din and dout alone
// - chop_enable bit in the filter register, one means chopping
module arf_top import arf_pkg::*; #(
	parameter int W = WORD_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk,
	input wire logic din,
	input wire logic cs_n,
	output logic dout,
	output logic dout_oe,
	output logic rdy_n,
	output logic chop_active,
	output logic conv_mode,
	output logic cal_run,
	input wire logic upd_start,
	input wire logic upd_done,
	input wire logic [W-1:0] upd_data,
	input wire logic cal_done,
	output logic irq
);
	localparam int LW = $clog2(W+1);
	generate
		if (W < COMM_W || W > 32) begin : g_bad_width
			$error("arf_top: W must lie in 8..32");
		end
	endgenerate
	// ==========================================
	// declarations
	arf_sp_if #(.W(W)) sp ();
	arf_state_e state;
	logic [COMM_W-1:0] comm;
	logic [W-1:0] mode_r;
	logic [W-1:0] filt;
	logic [W-1:0] dac;
	logic [W-1:0] offs;
	logic [W-1:0] gain;
	logic [W-1:0] data_r;
	logic [W-1:0] rd_word;
	logic cal_busy;
	logic [SEL_W-1:0] sel;
	logic [SEL_W-1:0] rx_sel;
	logic rx_rd;
	logic wr_ok;
	logic cmd_hit;
	logic wr_hit;
	logic rd_done;
	logic data_rd;
	logic bad_wr;
	logic cal_start;
	logic conv_live;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] stat;
	logic [IRQ_W-1:0] mask;
	logic apb_acc;
	logic apb_setup;
	logic mapped;
	// ==========================================
	// serial shifter
	arf_shifter #(.W(W)) u_shift (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.sclk(sclk),
		.din(din),
		.cs_n(cs_n),
		.dout(dout),
		.sp(sp.shifter)
	);
	assign dout_oe = sp.frame;
	// ==========================================
	// command decode
	assign sel = comm[SEL_LSB +: SEL_W];
	assign rx_sel = sp.rx_word[SEL_LSB +: SEL_W];
	assign rx_rd = sp.rx_word[COMM_RD_BIT];
	assign cmd_hit = ce && sp.frame && sp.done && state == ST_CMD;
	assign wr_hit = ce && sp.frame && sp.done && state == ST_WR;
	assign rd_done = ce && sp.frame && sp.done && state == ST_RD;
	assign data_rd = rd_done && sel == SEL_DATA;
	always_comb begin
		case (rx_sel)
			SEL_MODE, SEL_FILT, SEL_DAC, SEL_OFFS, SEL_GAIN: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	assign bad_wr = cmd_hit && !rx_rd && !wr_ok && rx_sel != SEL_COMM_STAT;
	assign cal_start = wr_hit && sel == SEL_MODE
		&& sp.rx_word[MODE_LSB +: MODE_W] == MODE_CAL;
	assign conv_mode = mode_r[MODE_LSB +: MODE_W] == MODE_CONV;
	assign conv_live = conv_mode && !cal_busy;
	assign cal_run = cal_busy;
	assign chop_active = filt[CHOP_BIT];
	// ==========================================
	// output word select
	always_comb begin
		rd_word = '0;
		case (sel)
			SEL_COMM_STAT: begin
				rd_word[STAT_RDY] = rdy_n;
				rd_word[STAT_CAL] = cal_busy;
				rd_word[STAT_CHOP] = filt[CHOP_BIT];
				rd_word[MODE_LSB +: MODE_W] = mode_r[MODE_LSB +: MODE_W];
			end
			SEL_DATA: rd_word = data_r;
			SEL_MODE: rd_word = mode_r;
			SEL_FILT: rd_word = filt;
			SEL_DAC: rd_word = dac;
			SEL_OFFS: rd_word = offs;
			SEL_GAIN: rd_word = gain;
			default: rd_word = '0;
		endcase
	end
	assign sp.tx_word = rd_word;
	always_comb begin
		if (state == ST_CMD || (state == ST_RD && sel == SEL_COMM_STAT)) begin
			sp.len = LW'(COMM_W);
		end else begin
			sp.len = LW'(W);
		end
	end
	// ==========================================
	// port sequencer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_CMD;
			comm <= COMM_RST;
			sp.load <= 1'b0;
		end else if (ce) begin
			sp.load <= 1'b0;
			if (!sp.frame) begin
				state <= ST_CMD;
			end else if (sp.done) begin
				case (state)
					ST_CMD: begin
						comm <= sp.rx_word[COMM_W-1:0];
						if (rx_rd) begin
							state <= ST_RD;
							sp.load <= 1'b1;
						end else if (wr_ok) begin
							state <= ST_WR;
						end
					end
					ST_RD: state <= ST_CMD;
					ST_WR: state <= ST_CMD;
					default: state <= ST_CMD;
				endcase
			end
		end
	end
	// ==========================================
	// internal registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_r <= W'(MODE_RST);
			filt <= W'(FILT_RST);
			dac <= W'(DAC_RST);
			offs <= W'(OFFS_RST);
			gain <= W'(GAIN_RST);
		end else if (wr_hit) begin
			case (sel)
				SEL_MODE: mode_r <= sp.rx_word;
				SEL_FILT: filt <= sp.rx_word;
				SEL_DAC: dac <= sp.rx_word;
				SEL_OFFS: offs <= sp.rx_word;
				SEL_GAIN: gain <= sp.rx_word;
				default: ;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			data_r <= '0;
		end else if (ce && conv_live && upd_done) begin
			data_r <= upd_data;
		end
	end
	// ==========================================
	// ready flag
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdy_n <= 1'b1;
			cal_busy <= 1'b0;
		end else if (ce) begin
			if (cal_start) begin
				rdy_n <= 1'b1;
				cal_busy <= 1'b1;
			end else if (cal_busy) begin
				if (cal_done) begin
					rdy_n <= 1'b0;
					cal_busy <= 1'b0;
				end
			end else if (conv_mode) begin
				if (upd_done) begin
					rdy_n <= 1'b0;
				end else if (upd_start) begin
					rdy_n <= 1'b1;
				end else if (data_rd) begin
					rdy_n <= 1'b1;
				end
			end
		end
	end
	// ==========================================
	// interrupt status
	always_comb begin
		ev = '0;
		ev[IRQ_NEW] = ce && conv_live && upd_done;
		ev[IRQ_CAL] = ce && cal_busy && cal_done && !cal_start;
		ev[IRQ_MISS] = ce && conv_live && upd_start && !rdy_n;
		ev[IRQ_BADWR] = bad_wr;
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			stat <= '0;
		end else if (apb_acc && !pwrite && paddr == OFF_IRQ_STAT) begin
			stat <= (stat & ~prdata[IRQ_W-1:0]) | ev;
		end else begin
			stat <= stat | ev;
		end
	end
	assign irq = |(stat & mask);
	// ==========================================
	// apb slave
	assign pready = ce;
	assign apb_setup = ce && psel && !penable;
	assign apb_acc = ce && psel && penable;
	always_comb begin
		case (paddr)
			OFF_IRQ_STAT, OFF_IRQ_MASK, OFF_STATE, OFF_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask <= '0;
		end else if (apb_acc && pwrite && paddr == OFF_IRQ_MASK) begin
			mask <= pwdata[IRQ_W-1:0];
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				OFF_IRQ_STAT: prdata[IRQ_W-1:0] <= stat;
				OFF_IRQ_MASK: prdata[IRQ_W-1:0] <= mask;
				OFF_STATE: begin
					prdata[STAT_RDY] <= rdy_n;
					prdata[STAT_CAL] <= cal_busy;
					prdata[STAT_CHOP] <= filt[CHOP_BIT];
					prdata[MODE_LSB +: MODE_W] <= mode_r[MODE_LSB +: MODE_W];
				end
				OFF_DATA: prdata[W-1:0] <= data_r;
				default: ;
			endcase
		end
	end
	// ==========================================
	// checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_NEW_WORD_RDY_LOW: assert property (
		ce && conv_live && !cal_start && upd_done
		|=> !rdy_n && data_r == $past(upd_data))
		else $error("rdy_n not low with new word");
	AST_READ_RDY_HIGH: assert property (
		ce && conv_live && !cal_start && data_rd && !upd_done && !upd_start
		|=> rdy_n)
		else $error("rdy_n not high after data read");
	AST_UPDATE_RDY_HIGH: assert property (
		ce && conv_live && !cal_start && upd_start && !upd_done
		|=> rdy_n)
		else $error("rdy_n not high during update");
	AST_CAL_START: assert property (
		ce && cal_start |=> rdy_n && cal_busy && cal_run)
		else $error("calibration start left rdy_n low");
	AST_CAL_END: assert property (
		ce && cal_busy && cal_done && !cal_start |=> !rdy_n && !cal_busy)
		else $error("calibration end left rdy_n high");
	AST_READ_ROUTES_FILTER: assert property (
		cmd_hit && rx_rd && rx_sel == SEL_FILT
		|=> sp.load && state == ST_RD && sp.tx_word == filt)
		else $error("filter word not loaded for read");
	AST_NO_DATA_WRITE: assert property (
		state == ST_WR |-> sel != SEL_DATA && sel != SEL_COMM_STAT)
		else $error("write phase for read-only register");
	AST_CHOP_FROM_FILTER: assert property (
		wr_hit && sel == SEL_FILT |=> chop_active == $past(sp.rx_word[CHOP_BIT]))
		else $error("chop_enable not taken from filter write");
	COV_DATA_READ: cover property (data_rd);
	COV_CAL_DONE: cover property (ev[IRQ_CAL]);
	COV_MISSED_READ: cover property (ev[IRQ_MISS]);
	COV_FILTER_WRITE: cover property (wr_hit && sel == SEL_FILT);
endmodule // arf_top

// ### arf_host.sv
// Purpose: serial host model at the far side of the port
// Assumes: sclk idles high, period 125 ns
// Notes: din changes on sclk fall, dout sampled on rise
`timescale 1ns/1ps
module arf_host (
	output logic sclk,
	output logic din,
	output logic cs_n,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic rdy_n
);
	logic tied;
	initial begin
		sclk = 1'b1;
		din = 1'b1;
		cs_n = 1'b1;
		tied = 1'b0;
	end
	// ==========================================
	// frame: command byte then n data bits
	task automatic xfer(input logic [7:0] cmd, input int n, input logic [23:0] wd,
		output logic [23:0] rd);
		logic [31:0] sh;
		int k;
		sh = {cmd, wd};
		rd = '0;
		k = 0;
		while (cmd === 8'h41 && rdy_n !== 1'b0 && k < 2000) begin
			#8;
			k++;
		end
		cs_n = 1'b0;
		#62.5;
		for (int i = 0; i < 8 + n; i++) begin
			sclk = 1'b0;
			din = sh[31];
			sh = sh << 1;
			#62.5;
			sclk = 1'b1;
			rd = {rd[22:0], dout & dout_oe};
			#62.5;
		end
		din = ~din;
		cs_n = ~tied;
		#62.5;
	endtask
endmodule // arf_host

// ### tb.sv
// Purpose: self-checking bench for the ready flag block
// Assumes: ce held high except for the final pready check, apb answers when pready high
// Notes: serial frames come from the host model
`timescale 1ns/1ps
module tb import arf_pkg::*;;
	logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic sclk, din, cs_n, dout, dout_oe, rdy_n, chop_active, conv_mode, cal_run;
	logic upd_start, upd_done, cal_done, e;
	logic [23:0] upd_data, sr;
	int failures, compares, cycles;
	arf_top u_arf_top (.ref_clk(ref_clk), .rst(rst), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
		.din(din), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .rdy_n(rdy_n),
		.chop_active(chop_active), .conv_mode(conv_mode), .cal_run(cal_run),
		.upd_start(upd_start), .upd_done(upd_done), .upd_data(upd_data),
		.cal_done(cal_done), .irq(irq));
	arf_host u_arf_host (.sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout),
		.dout_oe(dout_oe), .rdy_n(rdy_n));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic pulse(input int k, input logic [23:0] d);
		@(posedge ref_clk);
		upd_start <= (k == 0);
		upd_done <= (k == 1);
		cal_done <= (k == 2);
		upd_data <= d;
		@(posedge ref_clk);
		upd_start <= 1'b0;
		upd_done <= 1'b0;
		cal_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic sx(input logic [7:0] c, input int n, input logic [23:0] wd);
		u_arf_host.xfer(c, n, wd, sr);
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	// ==========================================
	// tests
	initial begin
		{rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
		{upd_start, upd_done, cal_done, upd_data} = '0;
		{failures, compares, cycles} = '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		apb(1'b0, OFF_STATE, 0);
		chk(r, 32'h0000_00A0);
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_0001);
		sx({5'h00, SEL_MODE}, 24, 24'h00_0001);
		chk(32'(conv_mode), 1);
		pulse(1, 24'h12_3456);
		chk(32'({rdy_n, irq}), 1);
		apb(1'b0, OFF_IRQ_STAT, 0);
		chk(r, 32'h0000_0001);
		chk(32'(irq), 0);
		sx({5'h08, SEL_DATA}, 24, 0);
		chk(32'({sr, rdy_n}), {7'h0, 24'h12_3456, 1'b1});
		pulse(1, 24'h00_ABCD);
		chk(32'(rdy_n), 0);
		pulse(0, 0);
		chk(32'(rdy_n), 1);
		pulse(1, 24'h00_BEEF);
		chk(32'(rdy_n), 0);
		apb(1'b0, OFF_IRQ_STAT, 0);
		chk(r, 32'h0000_0005);
		sx({5'h00, SEL_COMM_STAT}, 0, 0);
		sx({5'h00, SEL_DATA}, 0, 0);
		apb(1'b0, OFF_IRQ_STAT, 0);
		chk(r, 32'h0000_0008);
		apb(1'b0, OFF_DATA, 0);
		chk(r, 32'h00BE_EF00 >> 8);
		apb(1'b0, 12'h010, 0);
		chk({r[30:0], e}, 32'h0000_0001);
		apb(1'b1, OFF_IRQ_MASK, 32'h0000_000F);
		apb(1'b0, OFF_IRQ_MASK, 0);
		chk(r, 32'h0000_000F);
		for (int c = 0; c < 2; c++) begin
			sx({5'h00, SEL_FILT}, 24, 24'(c) << CHOP_BIT);
			chk(32'(chop_active), 32'(c));
			sx({5'h08, SEL_FILT}, 24, 0);
			chk(32'(sr), 32'(c) << CHOP_BIT);
			apb(1'b0, OFF_STATE, 0);
			chk(32'(r[STAT_CHOP]), 32'(c));
		end
		sx({5'h00, SEL_MODE}, 24, 24'h00_0002);
		chk(32'({rdy_n, cal_run}), 3);
		pulse(2, 0);
		chk(32'({rdy_n, cal_run}), 0);
		apb(1'b0, OFF_IRQ_STAT, 0);
		chk(r, 32'h0000_0002);
		sx({5'h08, SEL_COMM_STAT}, 8, 0);
		chk(32'(sr[7:0]), 32'h0000_0022);
		sx({5'h08, SEL_DAC}, 24, 0);
		chk(32'(sr), 32'(DAC_RST));
		sx({5'h08, SEL_OFFS}, 24, 0);
		chk(32'(sr), 32'(OFFS_RST));
		sx({5'h08, SEL_GAIN}, 24, 0);
		chk(32'(sr), 32'(GAIN_RST));
		u_arf_host.tied = 1'b1;
		sx({5'h08, SEL_FILT}, 24, 0);
		sx({5'h08, SEL_MODE}, 24, 0);
		chk(32'({cs_n, dout_oe, sr}), 32'h0100_0002);
		ce <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk(32'(pready), 0);
		ce <= 1'b1;
		wrap_up();
	end
endmodule // tb
